// file: verilog/frps_pkg.sv
package frps_pkg;
  // clock rate used to turn times into cycle counts
  localparam int unsigned CLK_MHZ          = 100;
  // times in microseconds, as printed
  localparam int unsigned RST_LOW_MIN_US   = 10;
  localparam int unsigned SEL_DELAY_US     = 10;
  localparam int unsigned POR_RECOV_US     = 35;
  localparam int unsigned DECODE_RECOV_US  = 40;
  localparam int unsigned READ_RECOV_US    = 35;
  localparam int unsigned PROG_RECOV_US    = 310;
  // times in milliseconds, as printed
  localparam int unsigned SE4K_RECOV_MS    = 12;
  localparam int unsigned BLK_RECOV_MS     = 25;
  localparam int unsigned CHIP_RECOV_MS    = 100;
  localparam int unsigned STWR_RECOV_MS    = 40;
  // default settle delay after the supply is good, a plain choice
  localparam int unsigned SETTLE_US        = 100;
  // least times round up to whole cycles
  localparam int unsigned RST_LOW_MIN_CYC  = RST_LOW_MIN_US * CLK_MHZ;
  localparam int unsigned POR_RECOV_CYC    = POR_RECOV_US * CLK_MHZ;
  localparam int unsigned DECODE_RECOV_CYC = DECODE_RECOV_US * CLK_MHZ;
  localparam int unsigned READ_RECOV_CYC   = READ_RECOV_US * CLK_MHZ;
  localparam int unsigned PROG_RECOV_CYC   = PROG_RECOV_US * CLK_MHZ;
  localparam int unsigned SE4K_RECOV_CYC   = SE4K_RECOV_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLK_RECOV_CYC    = BLK_RECOV_MS * 1000 * CLK_MHZ;
  localparam int unsigned CHIP_RECOV_CYC   = CHIP_RECOV_MS * 1000 * CLK_MHZ;
  localparam int unsigned STWR_RECOV_CYC   = STWR_RECOV_MS * 1000 * CLK_MHZ;
  localparam int unsigned SETTLE_CYC       = SETTLE_US * CLK_MHZ;
  // activity codes reported by the core
  typedef enum logic [2:0] {
    FRPS_ACT_IDLE   = 3'b000,
    FRPS_ACT_DECODE = 3'b001,
    FRPS_ACT_READ   = 3'b010,
    FRPS_ACT_PROG   = 3'b011,
    FRPS_ACT_SE4K   = 3'b100,
    FRPS_ACT_BLK    = 3'b101,
    FRPS_ACT_CHIP   = 3'b110,
    FRPS_ACT_STWR   = 3'b111
  } frps_act_t;
  typedef enum logic [1:0] {
    FRPS_ST_POWER   = 2'b00,
    FRPS_ST_RESET   = 2'b01,
    FRPS_ST_RECOVER = 2'b10,
    FRPS_ST_READY   = 2'b11
  } frps_state_t;
  localparam int unsigned CNT_W = 24;
endpackage : frps_pkg

// file: verilog/frps_sequencer.sv
// Operation
// - after reset, device is in standby with 3-byte addressing
// - reset returns all volatile bits, latch, busy, locks, to defaults
// - reset during program or erase aborts it at once
// - while reset is low, serial output floats and activity is minimal
// - reset during decoding needs 40 us recovery before commands
// - reset during read needs 35 us, during program 310 us
// - erase recovery is 12 ms sector, 25 ms block, 100 ms chip
// - reset during status write needs 40 ms recovery
// - after power-up device is in standby with write latch cleared
// - below write-inhibit threshold logic held in reset, commands ignored
// - after power-on reset, 35 us recovery before commands accepted
`timescale 1ns/100ps
module frps_sequencer #(
  parameter int unsigned SETTLE_CYC     = frps_pkg::SETTLE_CYC,      // supply settle delay
  parameter int unsigned RST_LOW_CYC    = frps_pkg::RST_LOW_MIN_CYC, // least reset low width
  parameter int unsigned POR_CYC        = frps_pkg::POR_RECOV_CYC,   // power-on recovery
  parameter int unsigned DECODE_CYC     = frps_pkg::DECODE_RECOV_CYC,
  parameter int unsigned READ_CYC       = frps_pkg::READ_RECOV_CYC,
  parameter int unsigned PROG_CYC       = frps_pkg::PROG_RECOV_CYC,
  parameter int unsigned SE4K_CYC       = frps_pkg::SE4K_RECOV_CYC,
  parameter int unsigned BLK_CYC        = frps_pkg::BLK_RECOV_CYC,
  parameter int unsigned CHIP_CYC       = frps_pkg::CHIP_RECOV_CYC,
  parameter int unsigned STWR_CYC       = frps_pkg::STWR_RECOV_CYC
) (
  input  wire logic       mclk,          // system clock, 100 MHz
  input  wire logic       rstn,          // asynchronous reset, active low
  input  wire logic       clkEn,         // clock enable, freezes state when low
  input  wire logic       supplyOk,      // supply above write_inhibit_threshold
  input  wire logic       restartN,      // dedicated reset pin, active low
  input  wire logic       selectN,       // chip select pin, active low
  input  wire logic       serialClk,     // serial clock pin, passed to core unregistered
  input  wire logic [2:0] coreActivity,  // what the core is doing now
  output logic            coreResetN,    // holds core volatile state in reset
  output logic            abortOp,       // one-cycle pulse, abort program, erase or status write
  output logic            addr3Byte,     // 3-byte addressing forced
  output logic            writeEnableLatchClr, // clears write_enable_latch
  output logic            soOe,          // serial output enable permit
  output logic            lowPower,      // minimum activity request
  output logic            coreSelectN,   // select gated to core
  output logic            coreClk,       // serial clock gated to core
  output logic            decodeEn,      // instruction decode permitted
  output logic            ready,         // device accepts commands
  output logic [1:0]      seqState       // sequencer state
);

  localparam int unsigned W = frps_pkg::CNT_W;

  frps_pkg::frps_state_t state_ff, nxt_state;
  logic [W-1:0]          cnt_ff, nxt_cnt;
  logic [W-1:0]          lowCnt_ff, nxt_lowCnt;
  logic                  settled_ff, nxt_settled;
  logic [2:0]            lastAct_ff, nxt_lastAct;

  // recovery length from what the reset interrupted
  function automatic logic [W-1:0] recovLen(input logic [2:0] act);
    logic [W-1:0] r;
    r = W'(READ_CYC);
    case (act)
      frps_pkg::FRPS_ACT_DECODE: r = W'(DECODE_CYC);
      frps_pkg::FRPS_ACT_READ:   r = W'(READ_CYC);
      frps_pkg::FRPS_ACT_PROG:   r = W'(PROG_CYC);
      frps_pkg::FRPS_ACT_SE4K:   r = W'(SE4K_CYC);
      frps_pkg::FRPS_ACT_BLK:    r = W'(BLK_CYC);
      frps_pkg::FRPS_ACT_CHIP:   r = W'(CHIP_CYC);
      frps_pkg::FRPS_ACT_STWR:   r = W'(STWR_CYC);
      default:                   r = W'(READ_CYC);
    endcase
    return r;
  endfunction : recovLen

  wire restartLow  = ~restartN;
  wire pulseValid  = (lowCnt_ff >= W'(RST_LOW_CYC));
  wire cntDone     = (cnt_ff == '0);
  wire isReady     = (state_ff == frps_pkg::FRPS_ST_READY);
  wire busyArray   = (coreActivity == frps_pkg::FRPS_ACT_PROG) || (coreActivity == frps_pkg::FRPS_ACT_SE4K) ||
                     (coreActivity == frps_pkg::FRPS_ACT_BLK)  || (coreActivity == frps_pkg::FRPS_ACT_CHIP) ||
                     (coreActivity == frps_pkg::FRPS_ACT_STWR);

  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_settled = settled_ff;
    nxt_lowCnt  = restartLow ? ((pulseValid) ? lowCnt_ff : lowCnt_ff + W'(1)) : '0;
    nxt_lastAct = lastAct_ff;
    case (state_ff)
      frps_pkg::FRPS_ST_POWER: begin
        if (!supplyOk) begin
          nxt_cnt     = W'(SETTLE_CYC);
          nxt_settled = 1'b0;
        end else if (!settled_ff) begin
          if (cntDone) begin
            nxt_settled = 1'b1;
            nxt_cnt     = W'(POR_CYC);
          end else begin
            nxt_cnt = cnt_ff - W'(1);
          end
        end else if (cntDone) begin
          nxt_state = frps_pkg::FRPS_ST_READY;
        end else begin
          nxt_cnt = cnt_ff - W'(1);
        end
      end
      frps_pkg::FRPS_ST_RESET: begin
        if (!restartLow) begin
          if (pulseValid) begin
            nxt_state = frps_pkg::FRPS_ST_RECOVER;
            nxt_cnt   = recovLen(lastAct_ff);
          end else begin
            nxt_state = frps_pkg::FRPS_ST_READY;
          end
        end
      end
      frps_pkg::FRPS_ST_RECOVER: begin
        if (restartLow) begin
          nxt_state = frps_pkg::FRPS_ST_RESET;
        end else if (cntDone) begin
          nxt_state = frps_pkg::FRPS_ST_READY;
        end else begin
          nxt_cnt = cnt_ff - W'(1);
        end
      end
      default: begin
        if (restartLow) begin
          nxt_state   = frps_pkg::FRPS_ST_RESET;
          nxt_lastAct = coreActivity;
        end
      end
    endcase
    if (!supplyOk) begin
      nxt_state   = frps_pkg::FRPS_ST_POWER;
      nxt_cnt     = W'(SETTLE_CYC);
      nxt_settled = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= frps_pkg::FRPS_ST_POWER;
      cnt_ff     <= W'(SETTLE_CYC);
      lowCnt_ff  <= '0;
      settled_ff <= 1'b0;
      lastAct_ff <= frps_pkg::FRPS_ACT_IDLE;
    end else if (clkEn) begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      lowCnt_ff  <= nxt_lowCnt;
      settled_ff <= nxt_settled;
      lastAct_ff <= nxt_lastAct;
    end
  end

  logic abort_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      abort_ff <= 1'b0;
    end else if (clkEn) begin
      // abort array operation at reset entry
      abort_ff <= isReady && restartLow && busyArray;
    end
  end

  wire inReset = (state_ff == frps_pkg::FRPS_ST_RESET) || (state_ff == frps_pkg::FRPS_ST_POWER);

  assign abortOp             = abort_ff;
  assign coreResetN          = ~inReset;
  assign writeEnableLatchClr = inReset;
  assign addr3Byte           = ~isReady;
  assign soOe                = isReady && restartN;
  assign lowPower            = (state_ff == frps_pkg::FRPS_ST_RESET);
  // select and clock ignored until ready
  assign coreSelectN         = isReady ? selectN : 1'b1;
  assign coreClk             = isReady ? serialClk : 1'b0;
  assign decodeEn            = isReady && restartN;
  assign ready               = isReady;
  assign seqState            = state_ff;

endmodule : frps_sequencer

// file: testbench/frps_sequencer_sva.sv
`timescale 1ns/100ps
module frps_sequencer_chk #(
  parameter int unsigned READ_CYC = 10, // read recovery
  parameter int unsigned POR_CYC  = 10  // power-on recovery
) (
  input wire logic       mclk,                // clock
  input wire logic       rstn,                // reset
  input wire logic       clkEn,               // enable
  input wire logic       supplyOk,            // supply good
  input wire logic       restartN,            // reset pin
  input wire logic       selectN,             // select pin
  input wire logic       serialClk,           // serial clock
  input wire logic [2:0] coreActivity,        // activity
  input wire logic       coreResetN,          // core reset
  input wire logic       abortOp,             // abort pulse
  input wire logic       addr3Byte,           // 3-byte mode
  input wire logic       writeEnableLatchClr, // latch clear
  input wire logic       soOe,                // output permit
  input wire logic       lowPower,            // low power
  input wire logic       coreSelectN,         // gated select
  input wire logic       coreClk,             // gated clock
  input wire logic       decodeEn,            // decode permit
  input wire logic       ready,               // ready
  input wire logic [1:0] seqState             // state
);
  localparam int unsigned MINR = (READ_CYC < POR_CYC) ? READ_CYC : POR_CYC;
  logic [23:0] recCnt_ff;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) recCnt_ff <= 24'h0;
    else if (seqState != 2'h2) recCnt_ff <= 24'h0;
    else if (clkEn) recCnt_ff <= recCnt_ff + 24'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence rstEntry; ready && clkEn && supplyOk && !restartN; endsequence
  sequence inReset; seqState == 2'h1; endsequence
  chk_abort_entry: assert property (rstEntry |=> inReset ##0 (abortOp == ($past(coreActivity) >= 3'h3)))
    else $error("abort on reset entry wrong");
  chk_abort_only: assert property (abortOp |-> inReset) else $error("abort outside reset");
  chk_reset_hold: assert property (inReset |-> !coreResetN && writeEnableLatchClr && lowPower)
    else $error("volatile state not held");
  chk_so_float: assert property (!restartN |-> !soOe && !decodeEn) else $error("output active in reset");
  chk_sel_block: assert property (!ready |-> coreSelectN && !coreClk && !decodeEn) else $error("select leaks");
  chk_addr_mode: assert property (!ready |-> addr3Byte) else $error("3-byte mode not forced");
  chk_power_hold: assert property (clkEn && !supplyOk |=> seqState == 2'h0 && !coreResetN)
    else $error("logic not held at low supply");
  chk_rec_len: assert property ($rose(ready) && $past(seqState) == 2'h2 |-> $past(recCnt_ff) >= MINR)
    else $error("recovery too short");
endmodule : frps_sequencer_chk
bind frps_sequencer frps_sequencer_chk #(.READ_CYC(READ_CYC), .POR_CYC(POR_CYC)) frps_sequencer_chk_inst (
  .mclk(mclk), .rstn(rstn), .clkEn(clkEn), .supplyOk(supplyOk), .restartN(restartN), .selectN(selectN),
  .serialClk(serialClk), .coreActivity(coreActivity), .coreResetN(coreResetN), .abortOp(abortOp),
  .addr3Byte(addr3Byte), .writeEnableLatchClr(writeEnableLatchClr), .soOe(soOe), .lowPower(lowPower),
  .coreSelectN(coreSelectN), .coreClk(coreClk), .decodeEn(decodeEn), .ready(ready), .seqState(seqState));

// file: testbench/frps_host.sv
`timescale 1ns/100ps
module frps_host #(
  parameter int unsigned SEL_CYC = 4 // restart_high_to_select_delay in cycles
) (
  input  wire logic       mclk,      // clock
  input  wire logic       go,        // start a restart pulse
  input  wire logic [7:0] lowLen,    // pulse width in cycles
  input  wire logic       rdy,       // device accepts commands
  output logic            restartN,  // reset pin
  output logic            selectN,   // select pin
  output logic            serialClk  // serial clock, still outside frames
);
  initial begin
    restartN = 1'b1;
    selectN = 1'b1;
    serialClk = 1'b0;
  end
  always @(posedge mclk) begin
    if (go) begin
      restartN <= 1'b0;
      repeat (lowLen) @(posedge mclk);
      restartN <= 1'b1;
      repeat (SEL_CYC) @(posedge mclk);
      while (rdy !== 1'b1) @(posedge mclk);
      selectN <= 1'b0;
      repeat (4) @(posedge mclk) serialClk <= ~serialClk;
      selectN <= 1'b1;
    end
  end
endmodule : frps_host

// file: testbench/flash_reset_power_on_sequencer_bench.sv
`timescale 1ns/100ps
module flash_reset_power_on_sequencer_bench;
  localparam int unsigned SET = 6, POR = 10, RLOW = 8;
  localparam int unsigned DEC = 12, RD = 10, PRG = 14, S4K = 16, BLK = 18, CHP = 20, STW = 22;
  logic mclk = 1'b0, rstn = 1'b0, clkEn = 1'b1, supplyOk = 1'b0, go = 1'b0;
  logic [2:0] coreActivity = 3'h0;
  logic [7:0] lowLen = 8'h8, lfsr = 8'h5f;
  logic restartN, selectN, serialClk, coreResetN, abortOp, addr3Byte, wlClr, soOe, lowPower, coreSelectN;
  logic coreClk, decodeEn, ready;
  logic [1:0] seqState;
  int errTotal = 0, checked = 0, cyc = 0, n;
  always #5 mclk = ~mclk;
  frps_sequencer #(.SETTLE_CYC(SET), .RST_LOW_CYC(RLOW), .POR_CYC(POR), .DECODE_CYC(DEC), .READ_CYC(RD),
    .PROG_CYC(PRG), .SE4K_CYC(S4K), .BLK_CYC(BLK), .CHIP_CYC(CHP), .STWR_CYC(STW)) frps_sequencer_inst (
    .mclk(mclk), .rstn(rstn), .clkEn(clkEn), .supplyOk(supplyOk), .restartN(restartN), .selectN(selectN),
    .serialClk(serialClk), .coreActivity(coreActivity), .coreResetN(coreResetN), .abortOp(abortOp),
    .addr3Byte(addr3Byte), .writeEnableLatchClr(wlClr), .soOe(soOe), .lowPower(lowPower),
    .coreSelectN(coreSelectN), .coreClk(coreClk), .decodeEn(decodeEn), .ready(ready), .seqState(seqState));
  frps_host frps_host_inst (.mclk(mclk), .go(go), .lowLen(lowLen), .rdy(ready), .restartN(restartN),
    .selectN(selectN), .serialClk(serialClk));
  function automatic int recov(input logic [2:0] a);
    case (a)
      3'h1: return DEC;
      3'h3: return PRG;
      3'h4: return S4K;
      3'h5: return BLK;
      3'h6: return CHP;
      3'h7: return STW;
      default: return RD;
    endcase
  endfunction : recov
  function automatic logic [7:0] nextLfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nextLfsr
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      errTotal++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
    checked++;
    if (g < lo || g > hi) begin
      errTotal++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : cmp_rng
  task automatic wait_ready(output int c);
    c = 0;
    while (ready !== 1'b1) begin
      @(negedge mclk);
      c++;
    end
  endtask : wait_ready
  task automatic pulse(input logic [7:0] len);
    lowLen = len;
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    @(negedge mclk);
  endtask : pulse
  task tally_and_finish;
    $display("checked %0d errors %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // bounded run: a stuck sequencer ends the test instead of hanging it
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errTotal++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    cmp_bit("coreResetN", 1'b0, coreResetN);
    cmp_bit("wlClr", 1'b1, wlClr);
    supplyOk = 1'b1;
    wait_ready(n);
    cmp_rng("powerOn", SET + POR, SET + POR + 4, n);
    cmp_bit("standby", 1'b1, coreResetN);
    for (int a = 0; a < 8; a++) begin
      lfsr = nextLfsr(lfsr);
      coreActivity = a[2:0];
      pulse(8'(RLOW + 1) + {6'h0, lfsr[1:0]});
      cmp_bit("abortOp", a >= 3, abortOp);
      cmp_bit("soOe", 1'b0, soOe);
      cmp_bit("lowPower", 1'b1, lowPower);
      cmp_bit("addr3Byte", 1'b1, addr3Byte);
      cmp_bit("wlClr", 1'b1, wlClr);
      @(posedge restartN);
      wait_ready(n);
      cmp_rng("recovery", recov(a[2:0]), recov(a[2:0]) + 4, n);
      coreActivity = lfsr[6:4];
      repeat (8) @(negedge mclk);
    end
    // a pulse below the least width must leave no recovery behind
    pulse(8'h3);
    @(posedge restartN);
    wait_ready(n);
    cmp_rng("shortPulse", 0, 3, n);
    repeat (8) @(negedge mclk);
    supplyOk = 1'b0;
    repeat (2) @(negedge mclk);
    cmp_bit("supplyDrop", 1'b0, ready);
    supplyOk = 1'b1;
    wait_ready(n);
    cmp_rng("powerAgain", SET + POR, SET + POR + 4, n);
    repeat (8) @(negedge mclk);
    // with the enable low a valid-width pulse must leave the state frozen
    clkEn = 1'b0;
    pulse(8'(RLOW + 2));
    cmp_bit("frozenReady", 1'b1, ready);
    cmp_bit("frozenDecode", 1'b0, decodeEn);
    @(posedge restartN);
    @(negedge mclk);
    clkEn = 1'b1;
    repeat (2) @(negedge mclk);
    cmp_bit("noResetSeen", 1'b1, ready);
    tally_and_finish;
  end
endmodule : flash_reset_power_on_sequencer_bench
